// *** error_status_pkg.sv ***
// Purpose: shared constants of the internal error status register
// Assumes: 125 MHz interface-side clock
// Notes: bit positions, offset, reset value and refresh timing
package error_status_pkg;

  // register placement on the host interface
  localparam logic [4:0] INTERNAL_ERROR_STATUS_OFFSET = 5'h18;
  localparam logic [7:0] INTERNAL_ERROR_STATUS_RESET = 8'h07;

  // field positions
  localparam int unsigned COMMON_FAULT_BIT = 6;
  localparam int unsigned PKG_OVERTEMP_BIT = 4;
  localparam int unsigned COLD_LAMP_BIT = 3;
  localparam int unsigned OUTPUTS_OFF_BIT = 2;
  localparam int unsigned POWER_SIDE_WAIT_BIT = 1;
  localparam int unsigned LINK_ERROR_BIT = 0;

  // serial modes whose every access clears the sticky flags
  localparam logic [1:0] SERIAL_MODE_0 = 2'h0;
  localparam logic [1:0] SERIAL_MODE_1 = 2'h1;

  // volatile flag refresh period
  localparam int unsigned CLK_FREQ_MHZ = 125;
  localparam int unsigned REFRESH_PERIOD_US = 35;
  localparam int unsigned REFRESH_CYCLES = REFRESH_PERIOD_US * CLK_FREQ_MHZ;

endpackage : error_status_pkg

// *** refresh_timer.sv ***
// Purpose: periodic strobe for refreshing volatile flags
// Assumes: one clock domain, asynchronous active-low reset
// Notes: one-cycle tick every PERIOD_CYCLES clocks
`timescale 1ns/1ps
module refresh_timer #(
  parameter int unsigned PERIOD_CYCLES = error_status_pkg::REFRESH_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // strobe
  output logic o_tick
);

  localparam logic [15:0] LAST_COUNT = 16'(PERIOD_CYCLES - 1);

  logic [15:0] count_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= 16'h0000;
    end else if (count_q == LAST_COUNT) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= (count_q == LAST_COUNT);
    end
  end

  // ticks never come closer than nine cycles apart
  AST_TICK_SPACING: assert property ( // RULE9
    @(posedge i_clk) disable iff (!i_reset_n)
    o_tick |=> !o_tick [*8])
  else $error("refresh tick repeated too early");

endmodule : refresh_timer

// *** internal_error_status.sv ***
// Purpose: internal error status register with global fault flags
// Assumes: host strobes and fault inputs synchronous to I_CLK_SYS
// Notes: read data registered one cycle after the read strobe
`timescale 1ns/1ps

// Summary of operation
// (RULE1) bit 6 is live OR of gated flags
// (RULE2) bit 4 tracks package overtemperature, unlatched
// (RULE3) bit 3 tracks cold lamp load, unlatched
// (RULE4) bit 2 latches when all outputs off
// (RULE5) flag clear means outputs follow drive data
// (RULE6) bit 1 latches when power side unready
// (RULE7) bit 0 latches on isolation link error
// (RULE8) sticky bits clear on access, serial modes 0/1
// (RULE9) volatile flags refreshed every 35 us
// (RULE10) sticky bits drive active-low error pin
// (RULE11) gated flag marks channel overcurrent or overtemperature
// (RULE12) set beats clear; reserved bits read zero
module internal_error_status #(
  parameter int unsigned REFRESH_CYCLES = error_status_pkg::REFRESH_CYCLES
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  // host register access
  input wire logic [4:0] I_ADDR,
  input wire logic I_RD,
  input wire logic I_WR,
  input wire logic I_SERIAL_ACCESS,
  input wire logic [1:0] I_SERIAL_MODE,
  output logic [7:0] O_RDATA,
  output logic O_RVALID,
  // per-channel and power-side fault inputs
  input wire logic [7:0] I_CH_GATED,
  input wire logic I_PKG_OVERTEMP,
  input wire logic I_COLD_LAMP,
  input wire logic I_INTERNAL_OFF,
  input wire logic I_OUTPUT_DISABLE_PIN,
  input wire logic I_POWER_NOT_READY,
  input wire logic I_LINK_ERR_PROCESS,
  input wire logic I_LINK_ERR_INTERFACE,
  // output drive data
  input wire logic [7:0] I_DRIVE,
  output logic [7:0] O_CHANNEL_DRIVE,
  // error pin, low while any sticky flag is set
  output logic O_ERROR_N
);

  logic common_fault_q;
  logic pkg_overtemp_q;
  logic cold_lamp_q;
  logic outputs_off_q;
  logic outputs_off_d;
  logic power_side_wait_q;
  logic power_side_wait_d;
  logic link_error_q;
  logic link_error_d;
  logic refresh_tick;
  logic reg_hit;
  logic sticky_clear;
  logic outputs_off_cond;
  logic link_error_cond;

  // assemble the register image; reserved bits stay zero
  function automatic logic [7:0] compose_status(
    input logic common_fault,
    input logic pkg_overtemp,
    input logic cold_lamp,
    input logic outputs_off,
    input logic power_wait,
    input logic link_error
  );
    logic [7:0] value;
    value = 8'h00; // RULE12
    value[error_status_pkg::COMMON_FAULT_BIT] = common_fault;
    value[error_status_pkg::PKG_OVERTEMP_BIT] = pkg_overtemp;
    value[error_status_pkg::COLD_LAMP_BIT] = cold_lamp;
    value[error_status_pkg::OUTPUTS_OFF_BIT] = outputs_off;
    value[error_status_pkg::POWER_SIDE_WAIT_BIT] = power_wait;
    value[error_status_pkg::LINK_ERROR_BIT] = link_error;
    return value;
  endfunction : compose_status

  refresh_timer #(
    .PERIOD_CYCLES(REFRESH_CYCLES)
  ) u_refresh_timer (
    .i_clk(I_CLK_SYS),
    .i_reset_n(I_RESET_N),
    .o_tick(refresh_tick)
  );

  // access decode
  assign reg_hit = (I_RD || I_WR) &&
    (I_ADDR == error_status_pkg::INTERNAL_ERROR_STATUS_OFFSET);
  assign sticky_clear = reg_hit || (I_SERIAL_ACCESS &&
    ((I_SERIAL_MODE == error_status_pkg::SERIAL_MODE_0) ||
     (I_SERIAL_MODE == error_status_pkg::SERIAL_MODE_1))); // RULE8

  // all channels off: internal fault, disable pin or all-zero drive
  assign outputs_off_cond = I_INTERNAL_OFF || I_OUTPUT_DISABLE_PIN ||
    (I_DRIVE == 8'h00); // RULE4
  assign link_error_cond = I_LINK_ERR_PROCESS || I_LINK_ERR_INTERFACE; // RULE7

  // sticky next values, set has priority over clear
  assign outputs_off_d = outputs_off_cond ||
    (outputs_off_q && !sticky_clear); // RULE4 RULE12
  assign power_side_wait_d = I_POWER_NOT_READY ||
    (power_side_wait_q && !sticky_clear); // RULE6 RULE12
  assign link_error_d = link_error_cond ||
    (link_error_q && !sticky_clear); // RULE7 RULE12

  // live common fault from the gated-drive flags
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      common_fault_q <= 1'b0;
    end else begin
      common_fault_q <= |I_CH_GATED; // RULE1 RULE11
    end
  end

  // volatile power-side flags
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pkg_overtemp_q <= 1'b0;
      cold_lamp_q <= 1'b0;
    end else if (refresh_tick) begin
      pkg_overtemp_q <= I_PKG_OVERTEMP; // RULE2 RULE9
      cold_lamp_q <= I_COLD_LAMP; // RULE3 RULE9
    end
  end

  // sticky flags
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      outputs_off_q <= error_status_pkg::INTERNAL_ERROR_STATUS_RESET[
        error_status_pkg::OUTPUTS_OFF_BIT];
      power_side_wait_q <= error_status_pkg::INTERNAL_ERROR_STATUS_RESET[
        error_status_pkg::POWER_SIDE_WAIT_BIT];
      link_error_q <= error_status_pkg::INTERNAL_ERROR_STATUS_RESET[
        error_status_pkg::LINK_ERROR_BIT];
    end else begin
      outputs_off_q <= outputs_off_d;
      power_side_wait_q <= power_side_wait_d;
      link_error_q <= link_error_d;
    end
  end

  // error pin
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_ERROR_N <= 1'b0;
    end else begin
      O_ERROR_N <= !(outputs_off_d || power_side_wait_d ||
        link_error_d); // RULE10
    end
  end

  // channel drive gated while the off condition holds
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_CHANNEL_DRIVE <= 8'h00;
    end else if (outputs_off_cond) begin
      O_CHANNEL_DRIVE <= 8'h00;
    end else begin
      O_CHANNEL_DRIVE <= I_DRIVE; // RULE5
    end
  end

  // read port returns the image before the clear
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RDATA <= 8'h00;
      O_RVALID <= 1'b0;
    end else begin
      O_RVALID <= reg_hit && I_RD;
      if (reg_hit && I_RD) begin
        O_RDATA <= compose_status(common_fault_q, pkg_overtemp_q,
          cold_lamp_q, outputs_off_q, power_side_wait_q, link_error_q);
      end else begin
        O_RDATA <= 8'h00;
      end
    end
  end

  // checks
  AST_COMMON_LIVE: assert property ( // RULE1
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    ##1 common_fault_q == $past(|I_CH_GATED))
  else $error("common fault does not follow gated flags");

  AST_VOLATILE_HOLD: assert property ( // RULE2
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    !refresh_tick |=> $stable(pkg_overtemp_q) && $stable(cold_lamp_q))
  else $error("volatile flag changed between refreshes");

  AST_VOLATILE_LOAD: assert property ( // RULE3
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    refresh_tick |=> pkg_overtemp_q == $past(I_PKG_OVERTEMP) &&
      cold_lamp_q == $past(I_COLD_LAMP))
  else $error("volatile flag not refreshed");

  AST_OFF_SET: assert property ( // RULE4
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    outputs_off_cond |=> outputs_off_q)
  else $error("outputs off flag not latched");

  AST_DRIVE_FOLLOW: assert property ( // RULE5
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    ##1 !outputs_off_q |-> O_CHANNEL_DRIVE == $past(I_DRIVE))
  else $error("drive not following data with flag clear");

  AST_WAIT_SET: assert property ( // RULE6
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_POWER_NOT_READY |=> power_side_wait_q [*1] ##0 !O_ERROR_N)
  else $error("power wait flag or error pin missed");

  AST_LINK_SET: assert property ( // RULE7
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (I_LINK_ERR_PROCESS || I_LINK_ERR_INTERFACE) && sticky_clear
      |=> link_error_q)
  else $error("link error lost against clear");

  AST_CLEAR: assert property ( // RULE8
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    sticky_clear && !link_error_cond && !I_POWER_NOT_READY
      |=> !link_error_q && !power_side_wait_q)
  else $error("sticky flags not cleared by access");

  AST_ERROR_PIN: assert property ( // RULE10
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    O_ERROR_N == !(outputs_off_q || power_side_wait_q || link_error_q))
  else $error("error pin disagrees with sticky flags");

  AST_RESERVED_ZERO: assert property ( // RULE12
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    O_RVALID |-> !O_RDATA[7] && !O_RDATA[5] &&
      O_RDATA[0] == $past(link_error_q))
  else $error("read data wrong or reserved bits set");

  COV_READ: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    O_RVALID && O_RDATA[error_status_pkg::LINK_ERROR_BIT]);
  COV_SERIAL_CLEAR: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_SERIAL_ACCESS && power_side_wait_q ##1 !power_side_wait_q);
  COV_SET_WINS: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    sticky_clear && I_POWER_NOT_READY);
  COV_REFRESH: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    refresh_tick ##1 pkg_overtemp_q);

endmodule : internal_error_status

// *** mcu_host_model.sv ***
// Purpose: host controller model driving register strobes
// Assumes: strobes change at the falling edge of i_clk
// Notes: one access per call, strobes last one cycle
`timescale 1ns/1ps
module mcu_host_model (
  // clock
  input wire logic i_clk,
  // register access strobes
  output logic [4:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic o_ser,
  output logic [1:0] o_mode
);
  initial begin
    o_addr = 5'h00;
    o_rd = 1'h0;
    o_wr = 1'h0;
    o_ser = 1'h0;
    o_mode = 2'h3;
  end
  // read, write or serial access, taken at the next rising edge
  task automatic access(logic [4:0] a, logic r, logic w, logic s,
                        logic [1:0] m);
    @(negedge i_clk);
    o_addr = a;
    o_rd = r;
    o_wr = w;
    o_ser = s;
    o_mode = m;
    @(negedge i_clk);
    o_rd = 1'h0;
    o_wr = 1'h0;
    o_ser = 1'h0;
    // released address does not keep its last value
    o_addr = ~a;
  endtask : access
endmodule : mcu_host_model

// *** internal_error_status_tb_top.sv ***
// Purpose: self-checking bench of the internal error status register
// Assumes: inputs change at falling edges, refresh shortened to 16
// Notes: expected read data queued, a monitor pops on each valid
`timescale 1ns/1ps
module internal_error_status_tb_top;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [4:0] addr;
  logic [1:0] mode;
  logic rd, wr, ser, rvalid, err_n;
  logic [7:0] rdata, cdrive, dsave;
  logic [7:0] gated = 8'h00;
  logic [7:0] drive = 8'h00;
  logic ot = 1'h0, lamp = 1'h0, ioff = 1'h0, dis = 1'h0;
  logic pnr = 1'h0, lep = 1'h0, lei = 1'h0;
  int err_total = 0;
  int n_compared = 0;
  int seed = 72815;
  logic [7:0] expq[$];

  initial forever #4 clk = ~clk;

  mcu_host_model host (.i_clk(clk), .o_addr(addr), .o_rd(rd),
    .o_wr(wr), .o_ser(ser), .o_mode(mode));

  internal_error_status #(.REFRESH_CYCLES(16)) dut (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_RD(rd),
    .I_WR(wr), .I_SERIAL_ACCESS(ser), .I_SERIAL_MODE(mode),
    .O_RDATA(rdata), .O_RVALID(rvalid), .I_CH_GATED(gated),
    .I_PKG_OVERTEMP(ot), .I_COLD_LAMP(lamp), .I_INTERNAL_OFF(ioff),
    .I_OUTPUT_DISABLE_PIN(dis), .I_POWER_NOT_READY(pnr),
    .I_LINK_ERR_PROCESS(lep), .I_LINK_ERR_INTERFACE(lei),
    .I_DRIVE(drive), .O_CHANNEL_DRIVE(cdrive), .O_ERROR_N(err_n));

  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic rd_exp(logic [7:0] e);
    expq.push_back(e);
    host.access(5'h18, 1'h1, 1'h0, 1'h0, 2'h3);
  endtask : rd_exp

  // one-cycle fault condition, k selects which
  task automatic pulse(int k);
    @(negedge clk);
    {pnr, lep, lei, ioff, dis} = 5'h10 >> k;
    if (k == 5) drive = 8'h00;
    @(negedge clk);
    {pnr, lep, lei, ioff, dis} = 5'h00;
    drive = dsave;
  endtask : pulse

  always @(negedge clk) begin
    if (rvalid === 1'h1) begin
      if (expq.size() == 0) check("unexpected valid", 8'h01, 8'h00);
      else check("read data", rdata, expq.pop_front());
    end
  end

  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

  initial begin
    dsave = 8'($random(seed)) | 8'h01;
    drive = dsave;
    cyc(3);
    rst_n = 1'h1;
    rd_exp(8'h07);
    rd_exp(8'h00);
    cyc(1);
    check("error pin", {7'h00, err_n}, 8'h01);
    check("channel drive", cdrive, dsave);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      pulse(k);
      check("error pin", {7'h00, err_n}, 8'h00);
      if (k > 2) check("gated drive", cdrive, 8'h00);
      rd_exp(k == 0 ? 8'h02 : k < 3 ? 8'h01 : 8'h04);
      rd_exp(8'h00);
    end
    // set condition in the very cycle of a clearing read
    for (int k = 0; k < 6; k++) begin
      expq.push_back(8'h00);
      fork
        host.access(5'h18, 1'h1, 1'h0, 1'h0, 2'h3);
        pulse(k);
      join
      rd_exp(k == 0 ? 8'h02 : k < 3 ? 8'h01 : 8'h04);
    end
    $display("test sticky done");
    gated = 8'($random(seed)) | 8'h01;
    ot = 1'h1;
    lamp = 1'h1;
    cyc(40);
    rd_exp(8'h58);
    gated = 8'h00;
    ot = 1'h0;
    lamp = 1'h0;
    cyc(40);
    rd_exp(8'h00);
    $display("test volatile done");
    for (int m = 0; m < 4; m++) begin
      pulse(0);
      host.access(5'h03, 1'h0, 1'h0, 1'h1, 2'(m));
      rd_exp(m < 2 ? 8'h00 : 8'h02);
    end
    pulse(0);
    host.access(5'h03, 1'h1, 1'h0, 1'h0, 2'h3);
    rd_exp(8'h02);
    pulse(0);
    host.access(5'h18, 1'h0, 1'h1, 1'h0, 2'h3);
    rd_exp(8'h00);
    cyc(3);
    check("pending reads", 8'(expq.size()), 8'h00);
    $display("test clear done");
    // reset again in mid-run: sticky image back to its reset value
    rst_n = 1'h0;
    cyc(3);
    check("error pin", {7'h00, err_n}, 8'h00);
    rst_n = 1'h1;
    rd_exp(8'h07);
    rd_exp(8'h00);
    cyc(3);
    check("pending reads", 8'(expq.size()), 8'h00);
    $display("test reset again done");
    give_verdict();
  end
endmodule : internal_error_status_tb_top
